// ==== rtl/dfc_filter_chain.sv ====
`timescale 1ns/1ps
module dfc_filter_chain (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire dfc_pkg::dfc_reg_req_type reg_req_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic smp_valid_i,
	input wire dfc_pkg::dfc_stereo_type smp_i,
	input wire logic mod_req_i,
	output logic mod_valid_o,
	output logic signed [15:0] mod_data_o,
	output logic dac_on_o
);
	import dfc_pkg::*;

	typedef enum logic [1:0] {ENG_IDLE, ENG_IIR, ENG_BQ, ENG_POST} dfc_eng_type;
	typedef struct packed {
		logic hit;
		logic bank;
		logic [5:0] idx;
		logic lsb;
	} dfc_caddr_type;

	// processing block to chain layout
	function automatic dfc_chain_type chain_of(input logic [7:0] pb);
		unique case (pb)
			proc_block_four: chain_of = '{1'b0, 3'h3, 1'b0, 1'b0, INTERP_A};
			proc_block_five: chain_of = '{1'b1, 3'h6, 1'b1, 1'b0, INTERP_A};
			proc_block_fifteen: chain_of = '{1'b1, 3'h6, 1'b1, 1'b0, INTERP_B};
			proc_block_six: chain_of = '{1'b1, 3'h6, 1'b0, 1'b0, INTERP_A};
			proc_block_sixteen: chain_of = '{1'b1, 3'h6, 1'b0, 1'b0, INTERP_B};
			proc_block_twenty: chain_of = '{1'b1, 3'h0, 1'b0, 1'b0, INTERP_C};
			proc_block_thirteen: chain_of = '{1'b0, 3'h4, 1'b1, 1'b0, INTERP_B};
			proc_block_fourteen: chain_of = '{1'b0, 3'h4, 1'b0, 1'b0, INTERP_B};
			proc_block_twenty_one: chain_of = '{1'b1, 3'h4, 1'b1, 1'b0, INTERP_C};
			proc_block_twenty_two: chain_of = '{1'b1, 3'h4, 1'b0, 1'b0, INTERP_C};
			proc_block_twenty_five: chain_of = '{1'b1, 3'h5, 1'b1, 1'b1, INTERP_A};
			default: chain_of = '{1'b1, 3'h0, 1'b0, 1'b0, INTERP_B}; // unknown blocks act as block 12
		endcase
	endfunction

	// page/offset to coefficient slot, even offset holds the upper byte
	function automatic dfc_caddr_type coef_addr(input logic [7:0] pg, input logic [6:0] ad);
		logic [6:0] rel;
		rel = ad - R_COEF_LO;
		coef_addr = '0;
		coef_addr.lsb = rel[0];
		coef_addr.bank = (pg == PG_B_BQ) || (pg == PG_B_IIR);
		if ((pg == PG_A_BQ || pg == PG_B_BQ) && ad >= R_COEF_LO && ad <= R_BQ_HI)
		begin
			coef_addr.hit = 1'b1;
			coef_addr.idx = rel[6:1];
		end
		else if ((pg == PG_A_IIR || pg == PG_B_IIR) && ad >= R_COEF_LO && ad <= R_IIR_HI)
		begin
			coef_addr.hit = 1'b1;
			coef_addr.idx = IIR_BASE + rel[6:1];
		end
	endfunction

	// 1.15 accumulator back to a saturated sample, msb flags clipping
	function automatic logic [16:0] sat16(input logic signed [39:0] a);
		if (a > 40'sh7FFF)
			sat16 = {1'b1, 16'h7FFF};
		else if (a < -40'sh8000)
			sat16 = {1'b1, 16'h8000};
		else
			sat16 = {1'b0, a[15:0]};
	endfunction

	// register file state
	logic [7:0] page_q, page_d;
	logic [1:0] osr_hi_q, osr_hi_d;
	logic [7:0] osr_lo_q, osr_lo_d, pblk_q, pblk_d, rdata_q, rdata_d;
	logic pwr_q, pwr_d, clip_q, clip_d, adapt_q, adapt_d, act_q, act_d, swap_q, swap_d;
	logic rvalid_q, rvalid_d;
	logic [1:0] src_q, src_d;
	logic [15:0] coef [2][NCOEF];

	// engine and output state
	dfc_eng_type st_q, st_d;
	logic [2:0] sec_q, sec_d;
	logic signed [15:0] x_q, x_d, tgt_q, tgt_d, out_q, out_d;
	logic signed [15:0] hx1 [7];
	logic signed [15:0] hx2 [7];
	logic signed [15:0] hy1 [7];
	logic signed [15:0] hy2 [7];
	logic [7:0] bcnt_q, bcnt_d;
	logic bph_q, bph_d, mval_q, mval_d;
	logic [10:0] ocnt_q, ocnt_d;

	dfc_chain_type cfg;
	dfc_caddr_type wca, rca;
	logic running, cacc, wbank, rbank, swap_now, clip_set;
	logic [2:0] s;
	logic [5:0] base;
	logic signed [15:0] c0, c1, c2, c3, c4, secy;
	logic signed [39:0] acc;
	logic [16:0] sres;
	logic [10:0] osr;

	assign cfg = chain_of(pblk_q);
	assign running = pwr_q;
	assign cacc = !running || adapt_q;
	assign wca = coef_addr(page_q, reg_req_i.addr);
	assign rca = wca;
	assign wbank = running ? ~act_q : wca.bank;
	assign rbank = running ? ~act_q : rca.bank;
	assign swap_now = smp_valid_i && swap_q && adapt_q && pwr_q;
	assign osr = ({osr_hi_q, osr_lo_q} == 10'h000) ? OSR_FULL : {1'b0, osr_hi_q, osr_lo_q};

	// register writes, swap handling and read answers
	always_comb
	begin
		page_d = page_q;
		osr_hi_d = osr_hi_q;
		osr_lo_d = osr_lo_q;
		pblk_d = pblk_q;
		pwr_d = pwr_q;
		src_d = src_q;
		adapt_d = adapt_q;
		act_d = act_q;
		swap_d = swap_q;
		rdata_d = rdata_q;
		rvalid_d = reg_req_i.rd;
		clip_d = clip_q;
		if (swap_now)
		begin
			act_d = ~act_q;
			swap_d = 1'b0;
		end
		if (!(adapt_q && pwr_q))
			swap_d = 1'b0;
		if (reg_req_i.wr)
		begin
			if (reg_req_i.addr == R_PAGE)
				page_d = reg_req_i.wdata;
			else if (page_q == PG_BASE)
			begin
				unique case (reg_req_i.addr)
					R_OSR_HI: osr_hi_d = reg_req_i.wdata[1:0];
					R_OSR_LO: osr_lo_d = reg_req_i.wdata;
					R_PBLK: pblk_d = reg_req_i.wdata;
					R_PWR:
					begin
						pwr_d = reg_req_i.wdata[B_PWR];
						src_d = reg_req_i.wdata[B_SRC_HI:B_SRC_LO];
					end
					default: ;
				endcase
			end
			else if (page_q == PG_A_BQ && reg_req_i.addr == R_ADAPT)
			begin
				adapt_d = reg_req_i.wdata[B_ADAPT_EN];
				if (reg_req_i.wdata[B_SWAP] && adapt_q && pwr_q)
					swap_d = 1'b1;
			end
		end
		if (reg_req_i.rd)
		begin
			rdata_d = 8'h00;
			if (reg_req_i.addr == R_PAGE)
				rdata_d = page_q;
			else if (page_q == PG_BASE)
			begin
				unique case (reg_req_i.addr)
					R_OSR_HI: rdata_d = {6'h00, osr_hi_q};
					R_OSR_LO: rdata_d = osr_lo_q;
					R_PBLK: rdata_d = pblk_q;
					R_PWR: rdata_d = {pwr_q, 1'b0, src_q, 4'h0};
					R_CLIP: rdata_d = {clip_q, 7'h00};
					default: ;
				endcase
			end
			else if (page_q == PG_A_BQ && reg_req_i.addr == R_ADAPT)
				rdata_d = {5'h00, adapt_q, act_q, swap_q};
			else if (rca.hit && cacc)
				rdata_d = rca.lsb ? coef[rbank][rca.idx][7:0] : coef[rbank][rca.idx][15:8];
		end
		// a clip in the same cycle as the clearing read survives
		if (reg_req_i.rd && page_q == PG_BASE && reg_req_i.addr == R_CLIP)
			clip_d = 1'b0;
		if (clip_set)
			clip_d = 1'b1;
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			page_q <= PG_BASE;
			osr_hi_q <= OSR_HI_RST;
			osr_lo_q <= OSR_LO_RST;
			pblk_q <= PBLK_RST;
			pwr_q <= 1'b0;
			src_q <= SRC_LEFT;
			adapt_q <= 1'b0;
			act_q <= 1'b0;
			swap_q <= 1'b0;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
			clip_q <= 1'b0;
		end
		else
		begin
			page_q <= page_d;
			osr_hi_q <= osr_hi_d;
			osr_lo_q <= osr_lo_d;
			pblk_q <= pblk_d;
			pwr_q <= pwr_d;
			src_q <= src_d;
			adapt_q <= adapt_d;
			act_q <= act_d;
			swap_q <= swap_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			clip_q <= clip_d;
		end
	end

	// coefficient store: byte writes, locked unless stopped or adaptive
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			for (int b = 0; b < 2; b++)
				for (int i = 0; i < NCOEF; i++)
					coef[b][i] <= ((i % COEF_PER_BQ == 0) || (i == IIR_BASE)) ? COEF_FLAT : COEF_ZERO;
		end
		else if (reg_req_i.wr && wca.hit && cacc)
		begin
			if (wca.lsb)
				coef[wbank][wca.idx][7:0] <= reg_req_i.wdata;
			else
				coef[wbank][wca.idx][15:8] <= reg_req_i.wdata;
		end
	end

	// one section per cycle; iir uses slot 6, biquads 0..5
	always_comb
	begin
		s = (st_q == ENG_IIR) ? 3'h6 : sec_q;
		base = (st_q == ENG_IIR) ? IIR_BASE : 6'(sec_q * COEF_PER_BQ);
		c0 = coef[act_q][base];
		c1 = coef[act_q][base + 6'h01];
		c2 = coef[act_q][base + 6'h02];
		c3 = (st_q == ENG_IIR) ? COEF_ZERO : coef[act_q][base + 6'h03];
		c4 = (st_q == ENG_IIR) ? COEF_ZERO : coef[act_q][base + 6'h04];
		if (st_q == ENG_IIR)
			acc = 40'(c0 * x_q) + 40'(c1 * hx1[s]) + 40'(c2 * hy1[s]);
		else
			acc = 40'(c0 * x_q) + 40'(2 * c1 * hx1[s]) + 40'(c2 * hx2[s]) + 40'(2 * c3 * hy1[s])
				+ 40'(c4 * hy2[s]);
		sres = sat16(acc >>> 15);
		secy = sres[15:0];
	end

	// section history follows the engine
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			for (int i = 0; i < 7; i++)
			begin
				hx1[i] <= 16'sh0000;
				hx2[i] <= 16'sh0000;
				hy1[i] <= 16'sh0000;
				hy2[i] <= 16'sh0000;
			end
		end
		else if (st_q == ENG_IIR || st_q == ENG_BQ)
		begin
			hx1[s] <= x_q;
			hx2[s] <= hx1[s];
			hy1[s] <= secy;
			hy2[s] <= hy1[s];
		end
	end

	// sample engine, post stage and interpolation toward the modulator
	always_comb
	begin
		logic signed [16:0] sum;
		logic signed [15:0] mag, post, step;
		logic [16:0] bres;
		sum = 17'(smp_i.left) + 17'(smp_i.right);
		st_d = st_q;
		sec_d = sec_q;
		x_d = x_q;
		tgt_d = tgt_q;
		bcnt_d = bcnt_q;
		bph_d = bph_q;
		clip_set = 1'b0;
		post = x_q;
		mag = x_q[15] ? -x_q : x_q;
		bres = '0;
		step = 16'sh0000;
		unique case (st_q)
			ENG_IDLE:
				if (smp_valid_i && pwr_q)
				begin
					unique case (src_q)
						SRC_LEFT: x_d = smp_i.left;
						SRC_RIGHT: x_d = smp_i.right;
						default: x_d = sum[16:1];
					endcase
					sec_d = 3'h0;
					st_d = cfg.iir ? ENG_IIR : (cfg.nbq != 3'h0 ? ENG_BQ : ENG_POST);
				end
			ENG_IIR:
			begin
				x_d = secy;
				clip_set = sres[16];
				st_d = (cfg.nbq != 3'h0) ? ENG_BQ : ENG_POST;
			end
			ENG_BQ:
			begin
				x_d = secy;
				clip_set = sres[16];
				sec_d = sec_q + 3'h1;
				if (sec_d >= cfg.nbq)
					st_d = ENG_POST;
			end
			ENG_POST:
			begin
				// hard knee: excess above threshold shrinks to a quarter
				if (cfg.range_compressor && mag > DRC_THRESH)
					post = x_q[15] ? -(DRC_THRESH + ((mag - DRC_THRESH) >>> 2))
						: DRC_THRESH + ((mag - DRC_THRESH) >>> 2);
				if (cfg.beep)
				begin
					bres = sat16(40'(post) + 40'(bph_q ? BEEP_AMP : -BEEP_AMP));
					post = bres[15:0];
					clip_set = bres[16];
					bcnt_d = (bcnt_q == BEEP_HALF) ? 8'h00 : bcnt_q + 8'h01;
					if (bcnt_q == BEEP_HALF)
						bph_d = ~bph_q;
				end
				tgt_d = post;
				st_d = ENG_IDLE;
			end
		endcase
		// interpolation smooths toward the target, harder for filter A;
		// it only approximates the real image rejection of each type
		unique case (cfg.interp)
			INTERP_A: step = (tgt_q - out_q) >>> 2;
			INTERP_B: step = (tgt_q - out_q) >>> 1;
			default: step = tgt_q - out_q;
		endcase
		out_d = out_q;
		ocnt_d = (st_q == ENG_POST) ? 11'h000 : ocnt_q;
		mval_d = 1'b0;
		if (mod_req_i && pwr_q && ocnt_q < osr && st_q != ENG_POST)
		begin
			out_d = out_q + step;
			ocnt_d = ocnt_q + 11'h001;
			mval_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			st_q <= ENG_IDLE;
			sec_q <= 3'h0;
			x_q <= 16'sh0000;
			tgt_q <= 16'sh0000;
			out_q <= 16'sh0000;
			bcnt_q <= 8'h00;
			bph_q <= 1'b0;
			ocnt_q <= 11'h000;
			mval_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			sec_q <= sec_d;
			x_q <= x_d;
			tgt_q <= tgt_d;
			out_q <= out_d;
			bcnt_q <= bcnt_d;
			bph_q <= bph_d;
			ocnt_q <= ocnt_d;
			mval_q <= mval_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign reg_rvalid_o = rvalid_q;
	assign mod_valid_o = mval_q;
	assign mod_data_o = out_q;
	assign dac_on_o = pwr_q;
endmodule // dfc_filter_chain

// ==== rtl/dfc_pkg.sv ====
package dfc_pkg;
	// register pages and offsets
	localparam logic [7:0] PG_BASE = 8'h00;
	localparam logic [7:0] PG_A_BQ = 8'h08;
	localparam logic [7:0] PG_A_IIR = 8'h09;
	localparam logic [7:0] PG_B_BQ = 8'h0C;
	localparam logic [7:0] PG_B_IIR = 8'h0D;
	localparam logic [6:0] R_PAGE = 7'h00;
	localparam logic [6:0] R_ADAPT = 7'h01;
	localparam logic [6:0] R_OSR_HI = 7'h0D;
	localparam logic [6:0] R_OSR_LO = 7'h0E;
	localparam logic [6:0] R_CLIP = 7'h27;
	localparam logic [6:0] R_PBLK = 7'h3C;
	localparam logic [6:0] R_PWR = 7'h3F;
	localparam logic [6:0] R_COEF_LO = 7'h02;
	localparam logic [6:0] R_BQ_HI = 7'h3D;
	localparam logic [6:0] R_IIR_HI = 7'h07;
	// bit positions
	localparam int B_PWR = 7;
	localparam int B_SRC_HI = 5;
	localparam int B_SRC_LO = 4;
	localparam int B_CLIP = 7;
	localparam int B_ADAPT_EN = 2;
	localparam int B_ACTIVE = 1;
	localparam int B_SWAP = 0;
	// reset values and encodings
	localparam logic [1:0] OSR_HI_RST = 2'h0;
	localparam logic [7:0] OSR_LO_RST = 8'h80;
	localparam logic [10:0] OSR_FULL = 11'h400;
	localparam logic [7:0] PBLK_RST = 8'h0C;
	localparam logic [1:0] SRC_LEFT = 2'h0;
	localparam logic [1:0] SRC_RIGHT = 2'h1;
	// coefficient store
	localparam int NCOEF = 33;
	localparam int COEF_PER_BQ = 5;
	localparam logic [5:0] IIR_BASE = 6'h1E;
	localparam logic [15:0] COEF_FLAT = 16'h7FFF;
	localparam logic [15:0] COEF_ZERO = 16'h0000;
	// post processing
	localparam logic signed [15:0] DRC_THRESH = 16'sh4000;
	localparam logic signed [15:0] BEEP_AMP = 16'sh0800;
	localparam logic [7:0] BEEP_HALF = 8'h18;
	// processing block numbers
	localparam logic [7:0] proc_block_four = 8'h04;
	localparam logic [7:0] proc_block_five = 8'h05;
	localparam logic [7:0] proc_block_six = 8'h06;
	localparam logic [7:0] proc_block_twelve = 8'h0C;
	localparam logic [7:0] proc_block_thirteen = 8'h0D;
	localparam logic [7:0] proc_block_fourteen = 8'h0E;
	localparam logic [7:0] proc_block_fifteen = 8'h0F;
	localparam logic [7:0] proc_block_sixteen = 8'h10;
	localparam logic [7:0] proc_block_twenty = 8'h14;
	localparam logic [7:0] proc_block_twenty_one = 8'h15;
	localparam logic [7:0] proc_block_twenty_two = 8'h16;
	localparam logic [7:0] proc_block_twenty_five = 8'h19;

	typedef enum logic [1:0] {INTERP_A, INTERP_B, INTERP_C} dfc_interp_type;

	typedef struct packed {
		logic iir;
		logic [2:0] nbq;
		logic range_compressor;
		logic beep;
		dfc_interp_type interp;
	} dfc_chain_type;

	typedef struct packed {
		logic signed [15:0] left;
		logic signed [15:0] right;
	} dfc_stereo_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} dfc_reg_req_type;
endpackage

// ==== verif/dfc_filter_chain_sva.sv ====
`timescale 1ns/1ps
module dfc_filter_chain_sva (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire dfc_pkg::dfc_reg_req_type reg_req_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire logic mod_req_i,
	input wire logic mod_valid_o,
	input wire logic dac_on_o
);
	import dfc_pkg::*;
	logic [7:0] page_d;
	logic [7:0] page_q;
	logic adapt_d;
	logic adapt_q;
	logic coef_rd;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// shadow of page and adaptive bit, so reads can be judged without the body
	always_comb
	begin
		page_d = page_q;
		adapt_d = adapt_q;
		if (reg_req_i.wr && reg_req_i.addr == R_PAGE)
			page_d = reg_req_i.wdata;
		else if (reg_req_i.wr && page_q == PG_A_BQ && reg_req_i.addr == R_ADAPT)
			adapt_d = reg_req_i.wdata[B_ADAPT_EN];
	end
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			page_q <= PG_BASE;
			adapt_q <= 1'b0;
		end
		else
		begin
			page_q <= page_d;
			adapt_q <= adapt_d;
		end
	end
	assign coef_rd = reg_req_i.rd && (page_q == PG_A_BQ || page_q == PG_B_BQ) && reg_req_i.addr >= R_COEF_LO;
	// register handshake
	property p_rvalid; reg_req_i.rd |=> reg_rvalid_o; endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_rvalid_pulse; reg_req_i.rd ##1 !reg_req_i.rd |=> !reg_rvalid_o; endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer too long");
	property p_rdata_hold; !reg_rvalid_o |-> $stable(reg_rdata_o); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	// power and modulator
	property p_pwr;
		reg_req_i.wr && page_q == PG_BASE && reg_req_i.addr == R_PWR |=> dac_on_o == $past(reg_req_i.wdata[B_PWR]);
	endproperty
	a_pwr: assert property (p_pwr) else $error("power bit not followed");
	property p_mod_valid; mod_valid_o |-> $past(mod_req_i) && $past(dac_on_o); endproperty
	a_mod_valid: assert property (p_mod_valid) else $error("word without request");
	property p_off_no_mod; !dac_on_o [*2] |-> !mod_valid_o; endproperty
	a_off_no_mod: assert property (p_off_no_mod) else $error("word while off");
	// coefficient lock and swap refusal
	property p_lock; coef_rd && dac_on_o && !adapt_q |=> reg_rdata_o == 8'h00; endproperty
	a_lock: assert property (p_lock) else $error("locked coefficient read");
	property p_swap_off;
		reg_req_i.rd && page_q == PG_A_BQ && reg_req_i.addr == R_ADAPT && !dac_on_o |=> !reg_rdata_o[B_SWAP];
	endproperty
	a_swap_off: assert property (p_swap_off) else $error("swap pending while off");
endmodule // dfc_filter_chain_sva

// ==== verif/dfc_filter_chain_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module dfc_filter_chain_tb;
	import dfc_pkg::*;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	dfc_reg_req_type reg_req;
	dfc_stereo_type smp;
	logic [7:0] rdata;
	logic rvalid;
	logic smp_valid;
	logic mod_req = 1'b0;
	logic mod_valid;
	logic signed [15:0] mod_data;
	logic dac_on;
	logic [7:0] q;
	logic [7:0] q2;
	int fails = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [7:0] blks [12] = '{proc_block_four, proc_block_five, proc_block_six, proc_block_twelve,
		proc_block_thirteen, proc_block_fourteen, proc_block_fifteen, proc_block_sixteen,
		proc_block_twenty, proc_block_twenty_one, proc_block_twenty_two, proc_block_twenty_five};
	always #20 sys_clk_i = ~sys_clk_i;
	dfc_filter_chain DUT (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.reg_req_i(reg_req),
		.reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid),
		.smp_valid_i(smp_valid),
		.smp_i(smp),
		.mod_req_i(mod_req),
		.mod_valid_o(mod_valid),
		.mod_data_o(mod_data),
		.dac_on_o(dac_on)
	);
	dfc_host_model host (
		.sys_clk_i(sys_clk_i),
		.reg_rdata_i(rdata),
		.reg_rvalid_i(rvalid),
		.reg_req_o(reg_req),
		.smp_valid_o(smp_valid),
		.smp_o(smp)
	);
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// the audio tests need some 2300 cycles; a hang ends here
	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			fails++;
			wrap_up();
		end
	end
	task automatic rchk(input logic [6:0] a, input logic [7:0] e);
		host.rd(a, q);
		`CHK(q, e)
	endtask
	// tolerance covers the flat sections each losing one lsb
	function automatic logic near(input logic signed [15:0] a, input logic signed [15:0] b);
		logic signed [16:0] d;
		d = a - b;
		return (d < 17'sd17) && (d > -17'sd17);
	endfunction
	// 66 back-to-back requests; only the ratio of 64 may be answered
	task automatic pull(output logic signed [15:0] f, output logic signed [15:0] l);
		int n;
		int c;
		c = 0;
		f = 'x;
		l = 'x;
		mod_req = 1'b1;
		for (n = 0; n < 68; n++)
		begin
			@(posedge sys_clk_i);
			#1;
			if (n == 65)
				mod_req = 1'b0;
			if (mod_valid === 1'b1)
			begin
				c++;
				if (c == 1)
					f = mod_data;
				l = mod_data;
			end
		end
		`CHK(c, 64)
	endtask
	// silence first, then a step: first word shows the filter, last the chain gain
	task automatic audio(input logic [7:0] b, input logic [7:0] p, input logic signed [15:0] l,
		input logic signed [15:0] r, input logic signed [15:0] e, input int k);
		logic signed [15:0] f;
		logic signed [15:0] w;
		host.wr(R_PBLK, b);
		host.wr(R_PWR, p);
		host.smp(16'sh0000, 16'sh0000);
		pull(f, w);
		host.smp(l, r);
		pull(f, w);
		if (k == 3)
			`CHK(near(w, e + 16'sh0800) | near(w, e - 16'sh0800), 1'b1)
		else
		begin
			`CHK(near(f, e >>> k), 1'b1)
			`CHK(near(w, e), 1'b1)
		end
	endtask
	initial
	begin
		int i;
		int k;
		logic signed [15:0] e;
		repeat (5) @(posedge sys_clk_i);
		#1;
		sys_rst_i = 1'b0;
		rchk(R_OSR_LO, 8'h80);
		rchk(R_OSR_HI, 8'h00);
		rchk(R_PBLK, 8'h0C);
		rchk(R_PWR, 8'h00);
		host.wr(R_CLIP, 8'hFF);
		rchk(R_CLIP, 8'h00);
		rchk(7'h50, 8'h00);
		host.wr(R_PAGE, PG_A_BQ);
		rchk(R_ADAPT, 8'h00);
		rchk(7'h02, 8'h7F);
		rchk(7'h03, 8'hFF);
		rchk(7'h0C, 8'h7F);
		rchk(7'h04, 8'h00);
		host.wr(R_PAGE, PG_B_IIR);
		rchk(7'h02, 8'h7F);
		$display("reset values done");
		host.wr(R_PAGE, PG_BASE);
		host.wr(R_OSR_LO, 8'h40);
		for (i = 0; i < 12; i++)
		begin
			e = (blks[i] inside {8'h05, 8'h0D, 8'h0F, 8'h15, 8'h19}) ? 16'sh4800 : 16'sh6000;
			k = (blks[i] == 8'h19) ? 3 : (blks[i] inside {8'h04, 8'h05, 8'h06}) ? 2 : (blks[i] > 8'h13) ? 0 : 1;
			audio(blks[i], 8'h80, 16'sh6000, 16'sh0000, e, k);
		end
		audio(8'h14, 8'h90, 16'sh0000, 16'sh6000, 16'sh6000, 0);
		audio(8'h14, 8'hA0, 16'sh5000, 16'sh7000, 16'sh6000, 0);
		$display("processing blocks done");
		host.wr(R_PWR, 8'h00);
		`CHK(dac_on, 1'b0)
		host.wr(R_PAGE, PG_B_BQ);
		host.coef(7'h04, 16'h1234);
		host.wr(R_PAGE, PG_A_BQ);
		host.coef(7'h04, 16'h5678);
		rchk(7'h04, 8'h56);
		$display("stopped writes done");
		host.wr(R_PAGE, PG_BASE);
		host.wr(R_PWR, 8'h80);
		`CHK(dac_on, 1'b1)
		// a large first-biquad N1 now in buffer A drives two steps into saturation
		host.wr(R_PBLK, proc_block_four);
		host.smp(16'sh6000, 16'sh0000);
		host.smp(16'sh6000, 16'sh0000);
		rchk(R_CLIP, 8'h80);
		rchk(R_CLIP, 8'h00);
		host.wr(R_PAGE, PG_A_BQ);
		host.wr(7'h04, 8'hAA);
		rchk(7'h04, 8'h00);
		host.wr(R_ADAPT, 8'h01);
		rchk(R_ADAPT, 8'h00);
		host.wr(R_ADAPT, 8'h04);
		rchk(7'h04, 8'h12);
		host.coef(7'h04, 16'h9ABC);
		host.wr(R_PAGE, PG_B_BQ);
		rchk(7'h04, 8'h9A);
		host.wr(R_PAGE, PG_A_BQ);
		host.swap_wait(q, q2);
		`CHK(q, 8'h05)
		`CHK(q2, 8'h06)
		rchk(7'h04, 8'h56);
		$display("swap done");
		wrap_up();
	end
endmodule // dfc_filter_chain_tb
bind dfc_filter_chain dfc_filter_chain_sva u_sva (
	.sys_clk_i(sys_clk_i),
	.sys_rst_i(sys_rst_i),
	.reg_req_i(reg_req_i),
	.reg_rdata_o(reg_rdata_o),
	.reg_rvalid_o(reg_rvalid_o),
	.mod_req_i(mod_req_i),
	.mod_valid_o(mod_valid_o),
	.dac_on_o(dac_on_o)
);

// ==== verif/dfc_host_model.sv ====
`timescale 1ns/1ps
module dfc_host_model (
	input wire logic sys_clk_i,
	input wire logic [7:0] reg_rdata_i,
	input wire logic reg_rvalid_i,
	output dfc_pkg::dfc_reg_req_type reg_req_o,
	output logic smp_valid_o,
	output dfc_pkg::dfc_stereo_type smp_o
);
	import dfc_pkg::*;
	// idle bus at time zero
	initial
	begin
		reg_req_o = '0;
		smp_valid_o = 1'b0;
		smp_o = '0;
	end
	// released data is inverted so a stale value cannot pass for a fresh one
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		#1;
		reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk_i);
		#1;
		reg_req_o.wr = 1'b0;
		reg_req_o.wdata = ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] q);
		int n;
		@(posedge sys_clk_i);
		#1;
		reg_req_o.addr = a;
		reg_req_o.rd = 1'b1;
		@(posedge sys_clk_i);
		#1;
		reg_req_o.rd = 1'b0;
		for (n = 0; n < 3 && reg_rvalid_i !== 1'b1; n++)
			@(posedge sys_clk_i) #1;
		q = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hXX;
	endtask
	// coefficient goes upper byte first, each byte alone
	task automatic coef(input logic [6:0] a, input logic [15:0] v);
		wr(a, v[15:8]);
		wr(a + 7'h01, v[7:0]);
	endtask
	// samples spaced well beyond the engine's busy time
	task automatic smp(input logic signed [15:0] l, input logic signed [15:0] r);
		@(posedge sys_clk_i);
		#1;
		smp_o = '{left: l, right: r};
		smp_valid_o = 1'b1;
		@(posedge sys_clk_i);
		#1;
		smp_valid_o = 1'b0;
		smp_o = ~smp_o;
		repeat (10) @(posedge sys_clk_i);
		#1;
	endtask
	// swap request, one sample, then poll before touching coefficients again
	task automatic swap_wait(output logic [7:0] pend, output logic [7:0] fin);
		int n;
		wr(R_ADAPT, 8'h05);
		rd(R_ADAPT, pend);
		smp(16'sh0000, 16'sh0000);
		fin = 8'hFF;
		for (n = 0; n < 4 && fin[B_SWAP] !== 1'b0; n++)
			rd(R_ADAPT, fin);
	endtask
endmodule // dfc_host_model
